/* include/cip_pkg.sv */
// Purpose: shared constants and types of the charger two-wire port
// Assumes: 100 MHz system clock on both ends
// Notes: register map is four writable bytes plus one status byte
`default_nettype none
package cip_pkg;

  localparam logic [6:0] CIP_SLAVE_ADDR = 7'h6B;
  localparam logic [4:0] CIP_HS_CODE = 5'h01; // upper five bits 00001
  localparam int CIP_NUM_RW = 4;
  localparam logic [2:0] CIP_IDX_STATUS = 3'h4;
  localparam logic [7:0] CIP_REG_RST = 8'h00;
  localparam logic [7:0] CIP_UNMAPPED = 8'hFF;
  localparam logic [3:0] CIP_BITS_BYTE = 4'h8;

  // bit timing of the master, quarter bit per phase
  localparam int CIP_CLK_NS = 10;
  localparam int CIP_FS_BIT_NS = 10000; // 100 kbps standard mode
  localparam int CIP_HS_BIT_NS = 295; // 3.4 Mbps, rounded up
  localparam int CIP_QTR_FS_CYC = (CIP_FS_BIT_NS + 4 * CIP_CLK_NS - 1) /
    (4 * CIP_CLK_NS);
  localparam int CIP_QTR_HS_CYC = (CIP_HS_BIT_NS + 4 * CIP_CLK_NS - 1) /
    (4 * CIP_CLK_NS);

  typedef logic [CIP_NUM_RW-1:0][7:0] cip_regs_t;

  typedef enum logic [1:0] {CIP_K_ADDR, CIP_K_PTR, CIP_K_DATA} cip_kind_t;

  typedef enum logic [2:0] {
    CIP_S_IDLE, CIP_S_RX, CIP_S_ACK, CIP_S_TX, CIP_S_MACK
  } cip_sst_t;

  typedef enum logic [1:0] {
    CIP_OP_START, CIP_OP_STOP, CIP_OP_WRITE, CIP_OP_READ
  } cip_op_t;

  typedef enum logic [1:0] {
    CIP_H_IDLE, CIP_H_START, CIP_H_STOP, CIP_H_BIT
  } cip_hst_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_p;
    logic sda_s1;
    logic sda_s2;
    logic sda_p;
    cip_sst_t st;
    cip_kind_t kind;
    logic [3:0] bits;
    logic [7:0] sh;
    logic rw;
    logic mack;
    logic [2:0] ptr;
    logic hs;
    logic sda_oe;
    cip_regs_t regs;
    logic wr;
  } cip_slv_t;

  typedef struct packed {
    cip_hst_t st;
    logic [1:0] ph;
    logic [15:0] cnt;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic [8:0] rx;
    logic [7:0] code;
    logic is_wr;
    logic first;
    logic hs;
    logic scl_oe;
    logic sda_oe;
    logic sda_s1;
    logic sda_s2;
    logic rsp_valid;
  } cip_mst_t;

endpackage
`default_nettype wire

/* include/cip_if.sv */
// Purpose: two-wire bus joining master and charger port
// Assumes: open-drain wires with pull-ups, enables pull low
// Notes: only the master drives the clock wire
`timescale 1ns/10ps
`default_nettype none
interface cip_if;
  logic scl_oe;
  logic m_sda_oe;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // wired-and with pull-ups: any enable pulls the wire low
  assign scl = ~scl_oe;
  assign sda = ~(m_sda_oe | s_sda_oe);

  modport master (output scl_oe, output m_sda_oe, input scl, input sda);
  modport slave (output s_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

/* design/cip_master.sv */
// Purpose: bus master issuing start, stop and byte transfers
// Assumes: one command at a time, no clock stretching by the slave
// Notes: high speed timing after a master code following a start
`timescale 1ns/10ps
`default_nettype none
module cip_master #(
  parameter int QTR_FS = cip_pkg::CIP_QTR_FS_CYC,
  parameter int QTR_HS = cip_pkg::CIP_QTR_HS_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  cip_if.master bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire cip_pkg::cip_op_t cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack,
  output logic hs_active
);
  import cip_pkg::*;

  cip_mst_t q, d;
  logic [15:0] qtr;

  // phase length follows the current speed mode
  assign qtr = q.hs ? 16'(QTR_HS - 1) : 16'(QTR_FS - 1);

  always_comb
  begin
    d = q;
    d.sda_s1 = bus.sda;
    d.sda_s2 = q.sda_s1;
    d.rsp_valid = 1'b0;
    if (q.st == CIP_H_IDLE)
    begin
      if (cmd_valid)
      begin
        d.cnt = 16'h0000;
        d.ph = 2'h0;
        d.bitn = 4'h0;
        case (cmd_op)
          CIP_OP_START: d.st = CIP_H_START;
          CIP_OP_STOP: d.st = CIP_H_STOP;
          CIP_OP_WRITE:
          begin
            d.st = CIP_H_BIT;
            d.sh = {cmd_data, 1'b1}; // release during ack
            d.code = cmd_data;
            d.is_wr = 1'b1;
          end
          default:
          begin
            d.st = CIP_H_BIT;
            d.sh = {8'hFF, cmd_last}; // ack all but last byte
            d.is_wr = 1'b0;
          end
        endcase
      end
    end
    else if (q.cnt != qtr)
      d.cnt = q.cnt + 16'h0001;
    else
    begin
      d.cnt = 16'h0000;
      d.ph = q.ph + 2'h1;
      case (q.st)
        // repeated start works from clock low as well
        CIP_H_START:
          case (q.ph)
            2'h0: d.sda_oe = 1'b0;
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b1; // sda falls with clock high
            default:
            begin
              d.scl_oe = 1'b1;
              d.first = 1'b1;
              d.st = CIP_H_IDLE;
            end
          endcase
        // stop also used to abandon a transfer
        CIP_H_STOP:
          case (q.ph)
            2'h0: d.sda_oe = 1'b1;
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b0; // sda rises with clock high
            default:
            begin
              d.hs = 1'b0; // back to full/standard speed
              d.st = CIP_H_IDLE;
            end
          endcase
        // data changes only with clock low
        CIP_H_BIT:
          case (q.ph)
            2'h0: d.sda_oe = ~q.sh[8];
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.rx = {q.rx[7:0], q.sda_s2};
            default:
            begin
              d.scl_oe = 1'b1;
              d.sh = {q.sh[7:0], 1'b1};
              if (q.bitn == CIP_BITS_BYTE)
              begin
                d.st = CIP_H_IDLE;
                d.rsp_valid = 1'b1;
                d.first = 1'b0;
                // master code right after a start
                if (q.is_wr && q.first && q.code[7:3] == CIP_HS_CODE)
                  d.hs = 1'b1;
              end
              else
                d.bitn = q.bitn + 4'h1;
            end
          endcase
        default: d.st = CIP_H_IDLE;
      endcase
    end
  end

  // state register, bus released at reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.st <= CIP_H_IDLE;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
    end
    else
      q <= d;
  end

  assign cmd_ready = (q.st == CIP_H_IDLE);
  assign bus.scl_oe = q.scl_oe;
  assign bus.m_sda_oe = q.sda_oe;
  assign rsp_valid = q.rsp_valid;
  assign rsp_data = q.rx[8:1];
  assign rsp_nack = q.rx[0];
  assign hs_active = q.hs;
endmodule
`default_nettype wire

/* design/cip_slave.sv */
// Purpose: charger port slave with five byte registers
// Assumes: bus wires oversampled by the system clock
// Notes: write pointer persists for reads; no pointer auto-increment
// What this block does
// - slave only, seven-bit addressing only
// - answer only the fixed address 1101011
// - start is sda falling, clock high
// - stop ends link, await start again
// - sda steady while clock high
// - acknowledge matching address on ninth clock
// - receiver acknowledges every data byte
// - nine-bit units, eight data, one ack
// - master stops an abandoned transfer
// - unmapped register reads return all ones
// - master code recognised, never acknowledged
// - repeated start after code, same framing
// - stop leaves high speed mode
// - master prefers repeated starts in high speed
// - first write: start, address, pointer, data
// - acknowledge each received byte
// - register loads at ack clock fall
// - further pointer and data pairs, same transfer
// - pointer low three bits select register
// - four writable registers, one read-only
// - standard, fast and high speed rates
`timescale 1ns/10ps
`default_nettype none
module cip_slave (
  input wire logic clk,
  input wire logic rst_n,
  cip_if.slave bus,
  output cip_pkg::cip_regs_t cfg,
  input wire logic [7:0] status,
  output logic wr_pulse,
  output logic [2:0] wr_index,
  output logic hs_mode
);
  import cip_pkg::*;

  cip_slv_t q, d;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] rx_byte;

  // register read mux: writable bank, status, else all ones
  function automatic logic [7:0] rd_byte(input cip_regs_t regs,
                                         input logic [7:0] stat,
                                         input logic [2:0] idx);
    logic [7:0] v;
    v = CIP_UNMAPPED;
    if (idx < 3'(CIP_NUM_RW))
      v = regs[idx[1:0]];
    else if (idx == CIP_IDX_STATUS)
      v = stat;
    return v;
  endfunction

  // edges from the second sync stage only, first stage feeds nothing else
  assign scl_rise = q.scl_s2 & ~q.scl_p;
  assign scl_fall = ~q.scl_s2 & q.scl_p;
  assign start_seen = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
  assign stop_seen = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
  assign rx_byte = q.sh;

  always_comb
  begin
    d = q;
    d.scl_s1 = bus.scl;
    d.scl_s2 = q.scl_s1;
    d.scl_p = q.scl_s2;
    d.sda_s1 = bus.sda;
    d.sda_s2 = q.sda_s1;
    d.sda_p = q.sda_s2;
    d.wr = 1'b0;
    // framing events take priority, clock is steady high then
    if (stop_seen)
    begin
      d.st = CIP_S_IDLE;
      d.hs = 1'b0;
      d.sda_oe = 1'b0;
    end
    else if (start_seen)
    begin
      // repeated start keeps high speed setting
      d.st = CIP_S_RX;
      d.kind = CIP_K_ADDR;
      d.bits = 4'h0;
      d.sda_oe = 1'b0;
    end
    else
      case (q.st)
        CIP_S_RX:
        begin
          // sample on clock rise, sda is stable while high
          if (scl_rise)
          begin
            d.sh = {q.sh[6:0], q.sda_s2};
            d.bits = q.bits + 4'h1;
          end
          else if (scl_fall && q.bits == CIP_BITS_BYTE)
          begin
            d.bits = 4'h0;
            case (q.kind)
              CIP_K_ADDR:
                // seven-bit compare only
                if (rx_byte[7:1] == CIP_SLAVE_ADDR)
                begin
                  d.rw = rx_byte[0];
                  d.st = CIP_S_ACK;
                  d.sda_oe = 1'b1;
                end
                else if (rx_byte[7:3] == CIP_HS_CODE)
                begin
                  d.hs = 1'b1; // no ack, wait for repeated start
                  d.st = CIP_S_IDLE;
                end
                else
                  d.st = CIP_S_IDLE; // not ours, ignore until start
              CIP_K_PTR:
              begin
                d.ptr = rx_byte[2:0];
                d.st = CIP_S_ACK;
                d.sda_oe = 1'b1;
              end
              default:
              begin
                d.st = CIP_S_ACK;
                d.sda_oe = 1'b1;
              end
            endcase
          end
        end
        CIP_S_ACK:
          // ack held through the whole ninth clock high
          if (scl_fall)
          begin
            d.sda_oe = 1'b0;
            case (q.kind)
              CIP_K_ADDR:
                if (q.rw)
                begin
                  // read returns last written pointer
                  d.sh = rd_byte(q.regs, status, q.ptr);
                  d.sda_oe = ~d.sh[7];
                  d.bits = 4'h0;
                  d.st = CIP_S_TX;
                end
                else
                begin
                  d.kind = CIP_K_PTR;
                  d.st = CIP_S_RX;
                end
              CIP_K_PTR:
              begin
                d.kind = CIP_K_DATA;
                d.st = CIP_S_RX;
              end
              default:
              begin
                // load at the falling edge ending the ack
                if (q.ptr < 3'(CIP_NUM_RW))
                begin
                  d.regs[q.ptr[1:0]] = q.sh;
                  d.wr = 1'b1;
                end
                d.kind = CIP_K_PTR;
                d.st = CIP_S_RX;
              end
            endcase
          end
        CIP_S_TX:
          // next bit driven only after the clock falls
          if (scl_fall)
          begin
            if (q.bits == CIP_BITS_BYTE - 4'h1)
            begin
              d.sda_oe = 1'b0; // hand sda to the master for its ack
              d.st = CIP_S_MACK;
            end
            else
            begin
              d.sh = {q.sh[6:0], 1'b1};
              d.sda_oe = ~q.sh[6];
              d.bits = q.bits + 4'h1;
            end
          end
        CIP_S_MACK:
          if (scl_rise)
            d.mack = q.sda_s2;
          else if (scl_fall)
          begin
            if (!q.mack)
            begin
              // master acked, send the same register again
              d.sh = rd_byte(q.regs, status, q.ptr);
              d.sda_oe = ~d.sh[7];
              d.bits = 4'h0;
              d.st = CIP_S_TX;
            end
            else
              d.st = CIP_S_IDLE; // nack ends the read, wait for stop
          end
        default: d.st = CIP_S_IDLE;
      endcase
  end

  // one register for all state; no clock enable, oversampling supports
  // all three rates as long as each clock phase spans a few cycles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.st <= CIP_S_IDLE;
      q.kind <= CIP_K_ADDR;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_p <= 1'b1;
      q.regs <= {CIP_NUM_RW{CIP_REG_RST}};
    end
    else
      q <= d;
  end

  // user side views of the register bank
  assign bus.s_sda_oe = q.sda_oe;
  assign cfg = q.regs;
  assign wr_pulse = q.wr;
  assign wr_index = q.ptr;
  assign hs_mode = q.hs;
endmodule
`default_nettype wire

/* bench/cip_wire_sva.sv */
// Purpose: wire checks between the two-wire master and the charger port
// Assumes: both ends joined by one cip_if, pull-ups on both wires
// Notes: pulse counter restarts at every start condition
`timescale 1ns/10ps
`default_nettype none
module cip_wire_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  import cip_pkg::*;
  logic scl_q;
  logic sda_q;
  logic first_q;
  logic rd_q;
  logic [3:0] bitc_q;
  logic [7:0] byte_q;
  wire logic st_c = scl && scl_q && sda_q && !sda;
  wire logic sp_c = scl && scl_q && !sda_q && sda;
  wire logic rise = scl && !scl_q;
  wire logic ninth = rise && bitc_q == 4'h8;

  // pulse number and first byte since start; nine pulses per unit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      first_q <= 1'b0;
      rd_q <= 1'b0;
      bitc_q <= 4'h0;
      byte_q <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (st_c)
      begin
        bitc_q <= 4'h0;
        first_q <= 1'b1;
      end
      else if (rise)
      begin
        bitc_q <= (bitc_q == 4'h8) ? 4'h0 : bitc_q + 4'h1;
        if (bitc_q < 4'h8)
          byte_q <= {byte_q[6:0], sda};
        if (bitc_q == 4'h8)
          first_q <= 1'b0;
        if (bitc_q == 4'h8 && first_q)
          rd_q <= byte_q[0];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // address byte: ack exactly when the seven bits match
  addr_ack_a: assert property (ninth && first_q &&
    byte_q[7:1] == CIP_SLAVE_ADDR |-> s_sda_oe) else $error("no addr ack");
  addr_ignore_a: assert property (ninth && first_q &&
    byte_q[7:1] != CIP_SLAVE_ADDR |-> !s_sda_oe) else $error("bad ack");
  ack_hold_a: assert property (rise && s_sda_oe |->
    s_sda_oe [*6]) else $error("sda low not held");
  sda_edge_a: assert property ($changed(s_sda_oe) |-> !scl)
    else $error("slave moved sda in high phase");
  no_fight_a: assert property (scl |-> !(s_sda_oe && m_sda_oe))
    else $error("both ends drive sda");
  write_quiet_a: assert property (rise && bitc_q < 4'h8 &&
    !first_q && !rd_q |-> !s_sda_oe) else $error("slave drove data");
  start_quiet_a: assert property (st_c |-> !s_sda_oe [*4])
    else $error("slave drives at start");
  stop_quiet_a: assert property (sp_c |-> !s_sda_oe [*8])
    else $error("slave drives after stop");

  cover property (ninth && first_q && s_sda_oe);
  cover property (ninth && first_q && byte_q[7:3] == CIP_HS_CODE);
  cover property (sp_c);
endmodule
`default_nettype wire

/* bench/test_charger_i2c_slave_port.sv */
// Purpose: self-checking bench joining master and charger port
// Assumes: quarter bit of 4 clocks, 3 in high speed, so 160/120 ns a bit
// Notes: reset and unmapped expectations come from the register map constants, address and cycle counts from AW, QF and QH, the rest are literals
`timescale 1ns/10ps
`default_nettype none
module test_charger_i2c_slave_port;
  import cip_pkg::*;
  logic clk;
  logic rst_n;
  logic cmd_valid;
  logic cmd_ready;
  cip_op_t cmd_op;
  logic [7:0] cmd_data;
  logic cmd_last;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_nack;
  logic hs_active;
  cip_regs_t cfg;
  logic [7:0] status;
  logic wr_pulse;
  logic [2:0] wr_index;
  logic hs_mode;
  logic [7:0] rd;
  logic nk;
  logic rv;
  logic scl_last_q = 1'b1;
  logic [2:0] wr_last = 3'h0;
  int ncyc = 0;
  logic [8:0] wire_sh = 9'h000;
  int n_pulse = 0;
  int n_wr = 0;
  int n_errors = 0;
  int num_checks = 0;
  localparam logic [7:0] AW = {CIP_SLAVE_ADDR, 1'b0};
  localparam logic [7:0] AR = {CIP_SLAVE_ADDR, 1'b1};
  // high speed kept shorter than full speed so the switch shows up
  localparam int QF = 4;
  localparam int QH = 3;

  cip_if bus_if ();
  cip_master #(.QTR_FS(QF), .QTR_HS(QH)) u_cip_master (.clk(clk),
    .rst_n(rst_n), .bus(bus_if), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .cmd_last(cmd_last), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_nack(rsp_nack), .hs_active(hs_active));
  cip_slave u_cip_slave (.clk(clk), .rst_n(rst_n), .bus(bus_if),
    .cfg(cfg), .status(status), .wr_pulse(wr_pulse),
    .wr_index(wr_index), .hs_mode(hs_mode));
  cip_wire_sva u_cip_wire_sva (.clk(clk), .rst_n(rst_n),
    .scl_oe(bus_if.scl_oe), .m_sda_oe(bus_if.m_sda_oe),
    .s_sda_oe(bus_if.s_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // wire monitor: pulses and data bits msb first, plus register writes
  always @(posedge clk)
  begin
    scl_last_q <= bus_if.scl;
    if (bus_if.scl && !scl_last_q)
    begin
      n_pulse <= n_pulse + 1;
      wire_sh <= {wire_sh[7:0], bus_if.sda};
    end
    if (wr_pulse === 1'b1)
    begin
      n_wr <= n_wr + 1;
      wr_last <= wr_index;
    end
  end

  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one command; master is idle on entry so the first edge takes it
  task automatic xfer(input cip_op_t op, input logic [7:0] d,
    input logic last);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_data <= d;
    cmd_last <= last;
    @(posedge clk);
    cmd_valid <= 1'b0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (cmd_ready !== 1'b1 && n < 2000);
    if (n >= 2000)
      check("cmd done", 8'h00, 8'h01);
    ncyc = n;
    rd = rsp_data;
    nk = rsp_nack;
    rv = rsp_valid;
  endtask

  task automatic put(input logic [7:0] d);
    xfer(CIP_OP_WRITE, d, 1'b0);
  endtask

  task automatic ack_is(input logic e);
    check("ack bit", {7'h0, nk}, {7'h0, e});
    check("rsp valid", {7'h0, rv}, 8'h01);
  endtask

  task automatic t_idle();
    check("idle wires", {6'h0, bus_if.scl, bus_if.sda}, 8'h03);
    check("hs reset", {7'h0, hs_mode}, 8'h00);
    for (int i = 0; i < CIP_NUM_RW; i++)
      check("cfg reset", cfg[i], CIP_REG_RST);
    $display("test idle done");
  endtask

  // pointer and data pairs in one transfer, read-only slot included
  task automatic t_write();
    int p0;
    int w0;
    w0 = n_wr;
    xfer(CIP_OP_START, 8'h00, 1'b0);
    p0 = n_pulse;
    put(AW);
    ack_is(1'b0);
    check("wire addr", wire_sh[8:1], AW);
    check("pulses", 8'(n_pulse - p0), 8'h09);
    check("fs byte", 8'(ncyc), 8'(36 * QF));
    for (int i = 0; i < 5; i++)
    begin
      put(8'(i));
      ack_is(1'b0);
      put(8'hA0 + 8'(i));
      ack_is(1'b0);
    end
    xfer(CIP_OP_STOP, 8'h00, 1'b0);
    repeat (5) @(posedge clk);
    for (int i = 0; i < CIP_NUM_RW; i++)
      check("cfg", cfg[i], 8'hA0 + 8'(i));
    check("writes", 8'(n_wr - w0), 8'h04);
    check("wr index", {5'h0, wr_last}, 8'h03);
    $display("test write done");
  endtask

  // pointer set, repeated start, read twice with ack then no ack
  task automatic t_read();
    logic [7:0] ptr [3];
    logic [7:0] exp [3];
    ptr = '{8'h01, 8'h04, 8'h06};
    exp = '{8'hA1, 8'h5E, CIP_UNMAPPED};
    @(posedge clk);
    status <= 8'h5E;
    for (int i = 0; i < 3; i++)
    begin
      xfer(CIP_OP_START, 8'h00, 1'b0);
      put(AW);
      put(ptr[i]);
      xfer(CIP_OP_START, 8'h00, 1'b0);
      put(AR);
      ack_is(1'b0);
      xfer(CIP_OP_READ, 8'h00, 1'b0);
      check("read", rd, exp[i]);
      xfer(CIP_OP_READ, 8'h00, 1'b1);
      check("reread", rd, exp[i]);
      xfer(CIP_OP_STOP, 8'h00, 1'b0);
    end
    $display("test read done");
  endtask

  // foreign, ten-bit header and bit-flipped addresses are ignored
  task automatic t_reject();
    logic [7:0] bad [4];
    bad = '{8'hD4, 8'hDE, 8'hF0, 8'h56};
    for (int i = 0; i < 4; i++)
    begin
      xfer(CIP_OP_START, 8'h00, 1'b0);
      put(bad[i]);
      ack_is(1'b1);
      put(8'h00);
      ack_is(1'b1);
      xfer(CIP_OP_STOP, 8'h00, 1'b0);
    end
    check("cfg kept", cfg[0], 8'hA0);
    $display("test reject done");
  endtask

  // pointer without data, abandoned by a stop, then a fresh write
  task automatic t_abort();
    xfer(CIP_OP_START, 8'h00, 1'b0);
    put(AW);
    put(8'h02);
    xfer(CIP_OP_STOP, 8'h00, 1'b0);
    check("no write", cfg[2], 8'hA2);
    xfer(CIP_OP_START, 8'h00, 1'b0);
    put(AW);
    put(8'h02);
    put(8'h99);
    xfer(CIP_OP_STOP, 8'h00, 1'b0);
    repeat (5) @(posedge clk);
    check("after abort", cfg[2], 8'h99);
    check("abort index", {5'h0, wr_last}, 8'h02);
    $display("test abort done");
  endtask

  task automatic t_hs();
    xfer(CIP_OP_START, 8'h00, 1'b0);
    put({CIP_HS_CODE, 3'h5});
    ack_is(1'b1);
    check("code byte", 8'(ncyc), 8'(36 * QF));
    repeat (4) @(posedge clk);
    check("slave hs", {7'h0, hs_mode}, 8'h01);
    check("master hs", {7'h0, hs_active}, 8'h01);
    xfer(CIP_OP_START, 8'h00, 1'b0);
    put(AW);
    ack_is(1'b0);
    check("hs byte", 8'(ncyc), 8'(36 * QH));
    put(8'h03);
    put(8'h5C);
    ack_is(1'b0);
    xfer(CIP_OP_STOP, 8'h00, 1'b0);
    repeat (5) @(posedge clk);
    check("hs left", {7'h0, hs_mode}, 8'h00);
    check("master hs left", {7'h0, hs_active}, 8'h00);
    check("hs write", cfg[3], 8'h5C);
    $display("test hs done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog well above the roughly 6700 cycles the tests take
  initial
  begin
    repeat (40000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  initial
  begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = CIP_OP_START;
    cmd_data = 8'h00;
    cmd_last = 1'b0;
    status = 8'h00;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    t_idle();
    t_write();
    t_read();
    t_reject();
    t_abort();
    t_hs();
    end_of_test();
  end
endmodule
`default_nettype wire
